// >>> verilog/irq_aggregator_defines.svh
// Offsets, field positions, reset values and widths of the dual pin interrupt aggregator
`ifndef IRQ_AGGREGATOR_DEFINES_SVH
`define IRQ_AGGREGATOR_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IRQA_WORD_W         48
`define IRQA_VEC_W          96

// ----------------------------------------------------------------
// Register map: byte address = bank * 16 + word * 4
// ----------------------------------------------------------------
`define IRQA_BANK_MASK_FIRST  3'h0
`define IRQA_BANK_MASK_SECOND 3'h1
`define IRQA_BANK_STICKY      3'h2
`define IRQA_BANK_STATUS      3'h3
`define IRQA_BANK_CLEAR       3'h4
`define IRQA_BANK_ENABLE      3'h5
`define IRQA_BANK_LSB         4
`define IRQA_WORD_LSB         2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IRQA_MASK_RST       96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF
`define IRQA_STICKY_RST     96'h0
`define IRQA_ENABLE_RST     96'h0
`define IRQA_STATUS_RST     96'h0

// ----------------------------------------------------------------
// Implemented source positions: lower 0..8 and 10..40, upper 0..40
// ----------------------------------------------------------------
`define IRQA_VALID          96'h01FF_FFFF_FFFF_01FF_FFFF_FDFF

// Lower word
`define IRQA_LO_FRAMER      0
`define IRQA_LO_RSVD        9
`define IRQA_LO_DEFRAMER    10
`define IRQA_LO_RX_SP       22
`define IRQA_LO_TX_SP       30
`define IRQA_LO_ORX_SP      38
`define IRQA_LO_CORE_SP     40
// Upper word
`define IRQA_UP_CPU         0
`define IRQA_UP_PA          10
`define IRQA_UP_PLL         26
`define IRQA_UP_SPI         33
`define IRQA_UP_UNUSED      41

`endif

// >>> verilog/irq_aggregator_pkg.sv
// Types shared by the dual pin interrupt aggregator
package irq_aggregator_pkg;

	// ----------------------------------------------------------------
	// Source vector: upper word above lower word
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [47:0] upper;
		logic [47:0] lower;
	} irq_vec_s;

	// ----------------------------------------------------------------
	// Register banks
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BANK_MASK_FIRST  = 3'h0,
		BANK_MASK_SECOND = 3'h1,
		BANK_STICKY      = 3'h2,
		BANK_STATUS      = 3'h3,
		BANK_CLEAR       = 3'h4,
		BANK_ENABLE      = 3'h5,
		BANK_NONE        = 3'h7
	} bank_e;

endpackage : irq_aggregator_pkg

// >>> verilog/dual_pin_irq_aggregator.sv
// Dual pin interrupt aggregator with Wishbone register access
//
// Implementation choices: the Wishbone register port and the register addresses.
`include "irq_aggregator_defines.svh"

module dual_pin_irq_aggregator (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Interrupt sources
	input  wire logic [8:0]  framer_evt_i,
	input  wire logic [11:0] deframer_evt_i,
	input  wire logic [7:0]  rx_sp_err_i,
	input  wire logic [7:0]  tx_sp_err_i,
	input  wire logic [1:0]  observation_receiver_sp_err_i,
	input  wire logic        core_sp_err_i,
	input  wire logic [9:0]  cpu_evt_i,
	input  wire logic [15:0] pa_prot_evt_i,
	input  wire logic [6:0]  pll_evt_i,
	input  wire logic [7:0]  spi_evt_i,
	// Interrupt outputs
	output logic             irq_out_first_o,
	output logic             irq_out_second_o,
	output logic             irq_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] get_word(input logic [95:0] v, input logic [1:0] w);
		logic [31:0] r;
		r = 32'h0;
		unique case (w)
			2'h0: r = v[31:0];
			2'h1: r = {16'h0, v[47:32]};
			2'h2: r = v[79:48];
			2'h3: r = {16'h0, v[95:80]};
		endcase
		return r;
	endfunction : get_word

	function automatic logic [95:0] put_word(input logic [95:0] v, input logic [1:0] w,
		input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] m;
		logic [95:0] r;
		m = get_word(v, w);
		r = v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		unique case (w)
			2'h0: r[31:0]  = m;
			2'h1: r[47:32] = m[15:0];
			2'h2: r[79:48] = m;
			2'h3: r[95:80] = m[15:0];
		endcase
		return r;
	endfunction : put_word

	function automatic irq_aggregator_pkg::bank_e decode_bank(input logic [7:0] adr);
		irq_aggregator_pkg::bank_e r;
		r = irq_aggregator_pkg::BANK_NONE;
		unique case (adr[`IRQA_BANK_LSB +: 3])
			`IRQA_BANK_MASK_FIRST:  r = irq_aggregator_pkg::BANK_MASK_FIRST;
			`IRQA_BANK_MASK_SECOND: r = irq_aggregator_pkg::BANK_MASK_SECOND;
			`IRQA_BANK_STICKY:      r = irq_aggregator_pkg::BANK_STICKY;
			`IRQA_BANK_STATUS:      r = irq_aggregator_pkg::BANK_STATUS;
			`IRQA_BANK_CLEAR:       r = irq_aggregator_pkg::BANK_CLEAR;
			`IRQA_BANK_ENABLE:      r = irq_aggregator_pkg::BANK_ENABLE;
			default:                r = irq_aggregator_pkg::BANK_NONE;
		endcase
		if (adr[1:0] != 2'h0) begin
			r = irq_aggregator_pkg::BANK_NONE;
		end
		return r;
	endfunction : decode_bank

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [95:0]                  mask_first_reg;
	logic [95:0]                  mask_second_reg;
	logic [95:0]                  sticky_reg;
	logic [95:0]                  enable_reg;
	logic [95:0]                  status_reg;
	logic [95:0]                  status_next;
	logic [95:0]                  clear_vec;
	logic [95:0]                  hold_vec;
	irq_aggregator_pkg::irq_vec_s src_vec;
	irq_aggregator_pkg::bank_e    bank;
	logic [1:0]                   word;
	logic                         req;
	logic                         wr_take;

	assign bank    = decode_bank(wb_adr_i);
	assign word    = wb_adr_i[`IRQA_WORD_LSB +: 2];
	assign req     = wb_cyc_i & wb_stb_i;
	assign wr_take = req & wb_we_i & wb_ack_o;

	// ----------------------------------------------------------------
	// Source vector assembly
	// ----------------------------------------------------------------
	always_comb begin
		src_vec = '0;
		src_vec.lower[`IRQA_LO_FRAMER +: 9]    = framer_evt_i;
		src_vec.lower[`IRQA_LO_DEFRAMER +: 12] = deframer_evt_i;
		src_vec.lower[`IRQA_LO_RX_SP +: 8]     = rx_sp_err_i;
		src_vec.lower[`IRQA_LO_TX_SP +: 8]     = tx_sp_err_i;
		src_vec.lower[`IRQA_LO_ORX_SP +: 2]    = observation_receiver_sp_err_i;
		src_vec.lower[`IRQA_LO_CORE_SP]        = core_sp_err_i;
		src_vec.upper[`IRQA_UP_CPU +: 10]      = cpu_evt_i;
		src_vec.upper[`IRQA_UP_PA +: 16]       = pa_prot_evt_i;
		src_vec.upper[`IRQA_UP_PLL +: 7]       = pll_evt_i;
		src_vec.upper[`IRQA_UP_SPI +: 8]       = spi_evt_i;
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0;
		end else if (req & ~wb_ack_o) begin
			unique case (bank)
				irq_aggregator_pkg::BANK_MASK_FIRST:  wb_dat_o <= get_word(mask_first_reg, word);
				irq_aggregator_pkg::BANK_MASK_SECOND: wb_dat_o <= get_word(mask_second_reg, word);
				irq_aggregator_pkg::BANK_STICKY:      wb_dat_o <= get_word(sticky_reg, word);
				irq_aggregator_pkg::BANK_STATUS:      wb_dat_o <= get_word(status_reg, word);
				irq_aggregator_pkg::BANK_ENABLE:      wb_dat_o <= get_word(enable_reg, word);
				default:                              wb_dat_o <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_first_reg  <= `IRQA_MASK_RST;
			mask_second_reg <= `IRQA_MASK_RST;
		end else if (wr_take) begin
			if (bank == irq_aggregator_pkg::BANK_MASK_FIRST) begin
				mask_first_reg <= put_word(mask_first_reg, word, wb_dat_i, wb_sel_i);
			end
			if (bank == irq_aggregator_pkg::BANK_MASK_SECOND) begin
				mask_second_reg <= put_word(mask_second_reg, word, wb_dat_i, wb_sel_i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sticky_reg <= `IRQA_STICKY_RST;
			enable_reg <= `IRQA_ENABLE_RST;
		end else if (wr_take) begin
			if (bank == irq_aggregator_pkg::BANK_STICKY) begin
				sticky_reg <= put_word(sticky_reg, word, wb_dat_i, wb_sel_i);
			end
			if (bank == irq_aggregator_pkg::BANK_ENABLE) begin
				enable_reg <= put_word(enable_reg, word, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ----------------------------------------------------------------
	// Status: sticky bits latch, others follow; set wins over clear
	// ----------------------------------------------------------------
	always_comb begin
		clear_vec = 96'h0;
		if (wr_take && bank == irq_aggregator_pkg::BANK_CLEAR) begin
			clear_vec = put_word(96'h0, word, wb_dat_i, wb_sel_i);
		end
	end

	assign hold_vec    = status_reg & sticky_reg & ~clear_vec;
	assign status_next = ((hold_vec | src_vec) & sticky_reg | src_vec & ~sticky_reg) & `IRQA_VALID;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= `IRQA_STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_out_first_o  <= 1'b0;
			irq_out_second_o <= 1'b0;
			irq_o            <= 1'b0;
		end else begin
			irq_out_first_o  <= |(status_reg & ~mask_first_reg);
			irq_out_second_o <= |(status_reg & ~mask_second_reg);
			irq_o            <= |(status_reg & enable_reg);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic any_first;
	logic any_second;
	assign any_first  = |(status_reg & ~mask_first_reg);
	assign any_second = |(status_reg & ~mask_second_reg);

	sequence core_err_seen;
		core_sp_err_i ##1 status_reg[`IRQA_LO_CORE_SP];
	endsequence

	chk_first_pin_or: assert property (@(posedge clk_i) disable iff (rst_i)
		any_first |=> irq_out_first_o)
		else $error("first pin missed an unmasked source");

	chk_second_pin_or: assert property (@(posedge clk_i) disable iff (rst_i)
		!any_second |=> !irq_out_second_o)
		else $error("second pin high with no unmasked source");

	chk_mask_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
		(&mask_first_reg) |=> !irq_out_first_o)
		else $error("fully masked first pin asserted");

	chk_reset_quiet: assert property (@(posedge clk_i)
		rst_i |=> !irq_out_first_o && !irq_out_second_o && (&mask_first_reg) && status_reg == 96'h0)
		else $error("reset left a pin high or a mask open");

	chk_sticky_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (status_reg & $past(hold_vec)) == $past(hold_vec))
		else $error("sticky status bit lost without a clear");

	chk_core_err_map: assert property (@(posedge clk_i) disable iff (rst_i)
		core_sp_err_i |-> core_err_seen)
		else $error("core stream error not at lower bit 40");

	chk_deframer_map: assert property (@(posedge clk_i) disable iff (rst_i)
		deframer_evt_i[11] |=> status_reg[`IRQA_LO_DEFRAMER + 11])
		else $error("deframer link drop not at lower bit 21");

	chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		status_reg[`IRQA_LO_RSVD] == 1'b0)
		else $error("reserved lower bit 9 set");

	chk_unused_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		status_reg[95:48 + `IRQA_UP_UNUSED] == 7'h0)
		else $error("unused upper status bits set");

	chk_cpu_map: assert property (@(posedge clk_i) disable iff (rst_i)
		cpu_evt_i[0] |=> status_reg[48 + `IRQA_UP_CPU])
		else $error("processor event not at upper bit 0");

	chk_mask_word_w: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_take && bank == irq_aggregator_pkg::BANK_MASK_FIRST && word == 2'h1 && wb_sel_i[0]
		|=> mask_first_reg[39:32] == $past(wb_dat_i[7:0]))
		else $error("lower mask high half not written");

	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	chk_mask_blocks_2nd: assert property (@(posedge clk_i) disable iff (rst_i)
		(&mask_second_reg) |=> !irq_out_second_o)
		else $error("fully masked second pin asserted");

	chk_level_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (status_reg & ~$past(sticky_reg)) == ($past(src_vec) & ~$past(sticky_reg) & `IRQA_VALID))
		else $error("level status bit did not follow its source");

	chk_clear_drops: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> (status_reg & $past(clear_vec & ~src_vec)) == 96'h0)
		else $error("cleared sticky bit stayed set with its source low");

endmodule : dual_pin_irq_aggregator

// >>> tb/irq_host_monitor.sv
// Baseband host model that watches both interrupt pins
module irq_host_monitor (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Interrupt pins
	input  wire logic irq_first_i,
	input  wire logic irq_second_i,
	// Rising edge counts
	output int        first_rises_o,
	output int        second_rises_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic first_d;
	logic second_d;

	// ----------------------------------------------------------------
	// Count rising edges, the cue for the host to read status
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			first_rises_o <= 0;
			second_rises_o <= 0;
		end else begin
			if (irq_first_i === 1'b1 && first_d !== 1'b1) first_rises_o <= first_rises_o + 1;
			if (irq_second_i === 1'b1 && second_d !== 1'b1) second_rises_o <= second_rises_o + 1;
		end
		first_d <= irq_first_i;
		second_d <= irq_second_i;
	end
endmodule : irq_host_monitor

// >>> tb/dual_pin_irq_aggregator_bench.sv
// Self-checking bench of the dual pin interrupt aggregator
module dual_pin_irq_aggregator_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// Implemented source positions: lower 0..8 and 10..40, upper 0..40
	localparam logic [95:0] VALID = {7'h00, 41'h1FF_FFFF_FFFF, 7'h00, 31'h7FFF_FFFF, 1'h0, 9'h1FF};
	localparam logic [95:0] B40   = 96'h1 << 40;

	logic        clk_i  = 1'h0;
	logic        rst_i  = 1'h1;
	logic        wb_cyc = 1'h0;
	logic        wb_stb = 1'h0;
	logic        wb_we  = 1'h0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [95:0] src    = 96'h0;
	logic [95:0] v;
	logic        irq_out_first_o;
	logic        irq_out_second_o;
	logic        irq_o;
	int          n_errors   = 0;
	int          num_checks = 0;
	int          cycles     = 0;
	int          r1;
	int          r2;
	int          b1;
	int          b2;

	always #5 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// Design and host model
	// ----------------------------------------------------------------
	dual_pin_irq_aggregator u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.framer_evt_i(src[8:0]), .deframer_evt_i(src[21:10]), .rx_sp_err_i(src[29:22]),
		.tx_sp_err_i(src[37:30]), .observation_receiver_sp_err_i(src[39:38]), .core_sp_err_i(src[40]),
		.cpu_evt_i(src[57:48]), .pa_prot_evt_i(src[73:58]), .pll_evt_i(src[80:74]), .spi_evt_i(src[88:81]),
		.irq_out_first_o(irq_out_first_o), .irq_out_second_o(irq_out_second_o), .irq_o(irq_o));

	irq_host_monitor u_host (.clk_i(clk_i), .rst_i(rst_i), .irq_first_i(irq_out_first_o),
		.irq_second_i(irq_out_second_o), .first_rises_o(r1), .second_rises_o(r2));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		if (n_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic pins(input logic [2:0] e);
		chk({93'h0, irq_o, irq_out_first_o, irq_out_second_o}, {93'h0, e});
	endtask : pins

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= s;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
	endtask : wb

	task automatic bank_io(input logic we, input logic [2:0] bank, inout logic [95:0] x);
		logic [127:0] p;
		logic [31:0]  q;
		p = {16'h0, x[95:80], x[79:48], 16'h0, x[47:32], x[31:0]};
		for (int w = 0; w < 4; w++) begin
			wb(we, {1'h0, bank, 2'(w), 2'h0}, p[w*32 +: 32], 4'hF, q);
			p[w*32 +: 32] = q;
		end
		if (!we) x = {p[111:64], p[47:0]};
	endtask : bank_io

	task automatic wr(input logic [2:0] bank, input logic [95:0] x);
		logic [95:0] t;
		t = x;
		bank_io(1'h1, bank, t);
	endtask : wr

	task automatic rd(input logic [2:0] bank, input logic [95:0] exp);
		logic [95:0] t;
		t = 96'h0;
		bank_io(1'h0, bank, t);
		chk(t, exp);
	endtask : rd

	// ----------------------------------------------------------------
	// Timeout
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		pins(3'h0);
		rd(3'h0, {96{1'h1}});
		rd(3'h1, {96{1'h1}});
		rd(3'h3, 96'h0);
		rd(3'h5, 96'h0);
		// Byte select: only lower mask bits 39..32 are written
		wb(1'h1, 8'h04, 32'h0, 4'h1, q);
		rd(3'h0, {{48{1'h1}}, 48'hFF00_FFFF_FFFF});
		// Unmapped place and read-only status ignore writes
		wb(1'h1, 8'h60, 32'hFFFF_FFFF, 4'hF, q);
		wb(1'h0, 8'h60, 32'h0, 4'hF, q);
		chk({64'h0, q}, 96'h0);
		wr(3'h3, {96{1'h1}});
		rd(3'h3, 96'h0);
		// Level source through the first pin, and through irq_o once enabled; the second pin stays low
		wr(3'h0, ~B40);
		src <= B40;
		repeat (3) @(posedge clk_i);
		pins(3'h2);
		rd(3'h3, B40);
		wr(3'h5, B40);
		repeat (3) @(posedge clk_i);
		pins(3'h6);
		wr(3'h5, 96'h0);
		repeat (3) @(posedge clk_i);
		pins(3'h2);
		src <= 96'h0;
		repeat (3) @(posedge clk_i);
		pins(3'h0);
		// Sticky pulse holds until cleared
		wr(3'h2, B40);
		rd(3'h2, B40);
		wr(3'h5, B40);
		src <= B40;
		@(posedge clk_i);
		src <= 96'h0;
		repeat (4) @(posedge clk_i);
		pins(3'h6);
		rd(3'h3, B40);
		rd(3'h4, 96'h0);
		wr(3'h4, B40);
		repeat (3) @(posedge clk_i);
		pins(3'h0);
		rd(3'h3, 96'h0);
		wr(3'h2, 96'h0);
		wr(3'h5, 96'h0);
		// Every source position: lower word on first pin, upper word on second
		wr(3'h0, {{48{1'h1}}, 48'h0});
		wr(3'h1, {48'h0, {48{1'h1}}});
		b1 = r1;
		b2 = r2;
		for (int i = 0; i < 96; i++) begin
			src <= 96'h1 << i;
			repeat (3) @(posedge clk_i);
			v = VALID & (96'h1 << i);
			pins({1'h0, |v[47:0], |v[95:48]});
			rd(3'h3, v);
			src <= 96'h0;
			repeat (3) @(posedge clk_i);
		end
		chk(96'(r1 - b1), 96'd40);
		chk(96'(r2 - b2), 96'd41);
		test_done();
	end
endmodule : dual_pin_irq_aggregator_bench
